// ==== hdl/pldc_top.sv ====
`timescale 1ns/10ps
// Behaviour
// - each logical device has own activation register
// - activation bit one enables device on bus
// - unused activation and check bits read zero
// - check with pattern bit one answers 55h
// - check with pattern bit zero answers AAh
// - check enable bit, effective only while inactive
// - descriptor zero base at 60h high, 61h low
// - high byte bits 7 to 3 read zero
// - descriptor one base at 62h high, 63h low
// - low four bits pick interrupt level, zero none
// - type bit zero: edge or level signalling; stored only, both pass the request as a level
// - polarity bit one: active high push-pull
// - polarity bit zero: low, open-drain, brief pull-up
// - interrupt type register may be read-only
// - first DMA select low three bits channel
// - second DMA select low three bits channel
// - DMA channel four means no channel
// - accesses apply to selected logical device only
module pldc_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic [pldc_pkg::NUM_DEV-1:0] irq_req_i,
  output logic [7:0] io_data_o,
  output logic io_drive_o,
  output logic [pldc_pkg::NUM_DEV-1:0] io_sel_o,
  output pldc_pkg::pldc_dev_t [pldc_pkg::NUM_DEV-1:0] dev_cfg_o,
  output logic [pldc_pkg::NUM_DEV-1:0] irq_valid_o,
  output logic [pldc_pkg::NUM_DEV-1:0] dma0_valid_o,
  output logic [pldc_pkg::NUM_DEV-1:0] dma1_valid_o,
  output logic [pldc_pkg::NUM_DEV-1:0] irq_pin_o,
  output logic [pldc_pkg::NUM_DEV-1:0] irq_oe_n_o
);
  pldc_pkg::pldc_state_t st_reg;
  pldc_pkg::pldc_state_t st_next;

  // decode helpers for the io range of every device
  logic [pldc_pkg::NUM_DEV-1:0] in_range;
  logic [15:0] base0 [pldc_pkg::NUM_DEV];
  logic [15:0] base1 [pldc_pkg::NUM_DEV];

  // a zero base is taken as unassigned so an idle device never decodes
  always_comb begin
    for (int d = 0; d < pldc_pkg::NUM_DEV; d++) begin
      base0[d] = {5'h0_0, st_reg.dev[d].b0h, st_reg.dev[d].b0l};
      base1[d] = {5'h0_0, st_reg.dev[d].b1h, st_reg.dev[d].b1l};
      in_range[d] = ((base0[d] != 16'h0000) &&
                     ((io_addr_i - base0[d]) < pldc_pkg::IO_RANGE_LEN)) ||
                    ((base1[d] != 16'h0000) &&
                     ((io_addr_i - base1[d]) < pldc_pkg::IO_RANGE_LEN));
    end
  end

  // selected device, or none when the number is out of range
  logic sel_ok;
  logic [1:0] sel;
  assign sel_ok = st_reg.ldn < pldc_pkg::NUM_DEV_B;
  assign sel = st_reg.ldn[1:0];

  // next state: register writes, read mux, io answer, irq pins
  always_comb begin
    logic [7:0] rd_val;
    logic asserted;
    logic pat_hit;
    rd_val = pldc_pkg::ZERO_B;
    asserted = 1'b0;
    pat_hit = 1'b0;
    st_next = st_reg;

    // card-level device number lives here so the copies can be chosen
    if (cfg_wr_i && cfg_addr_i == pldc_pkg::IDX_LDN) begin
      st_next.ldn = cfg_wdata_i;
    end

    // writes land only in the selected copy
    if (cfg_wr_i && sel_ok) begin
      case (cfg_addr_i)
        pldc_pkg::IDX_ACT: begin
          st_next.dev[sel].act = cfg_wdata_i[pldc_pkg::ACT_BIT];
        end
        pldc_pkg::IDX_RC: begin
          st_next.dev[sel].rc_en = cfg_wdata_i[pldc_pkg::RC_EN_BIT];
          st_next.dev[sel].rc_pat = cfg_wdata_i[pldc_pkg::RC_PAT_BIT];
        end
        pldc_pkg::IDX_B0H: st_next.dev[sel].b0h = cfg_wdata_i[2:0];
        pldc_pkg::IDX_B0L: st_next.dev[sel].b0l = cfg_wdata_i;
        pldc_pkg::IDX_B1H: st_next.dev[sel].b1h = cfg_wdata_i[2:0];
        pldc_pkg::IDX_B1L: st_next.dev[sel].b1l = cfg_wdata_i;
        pldc_pkg::IDX_INTERRUPT_REQUEST_LEVEL: st_next.dev[sel].interrupt_request_level = cfg_wdata_i[3:0];
        pldc_pkg::IDX_ITYP: begin
          // level and polarity bits; bits outside the mask keep their value
          st_next.dev[sel].ityp = (cfg_wdata_i[1:0] & pldc_pkg::ITYP_WR_MASK) |
                                  (st_reg.dev[sel].ityp & ~pldc_pkg::ITYP_WR_MASK);
        end
        pldc_pkg::IDX_DMA0: st_next.dev[sel].dma0 = cfg_wdata_i[2:0];
        pldc_pkg::IDX_DMA1: st_next.dev[sel].dma1 = cfg_wdata_i[2:0];
        default: begin
        end
      endcase
    end

    // read mux; unused bits come back as zero
    if (cfg_addr_i == pldc_pkg::IDX_LDN) begin
      rd_val = st_reg.ldn;
    end else if (sel_ok) begin
      case (cfg_addr_i)
        pldc_pkg::IDX_ACT: rd_val = {7'h0_0, st_reg.dev[sel].act};
        pldc_pkg::IDX_RC: rd_val = {6'h0_0, st_reg.dev[sel].rc_en,
                                    st_reg.dev[sel].rc_pat};
        pldc_pkg::IDX_B0H: rd_val = {5'h0_0, st_reg.dev[sel].b0h};
        pldc_pkg::IDX_B0L: rd_val = st_reg.dev[sel].b0l;
        pldc_pkg::IDX_B1H: rd_val = {5'h0_0, st_reg.dev[sel].b1h};
        pldc_pkg::IDX_B1L: rd_val = st_reg.dev[sel].b1l;
        pldc_pkg::IDX_INTERRUPT_REQUEST_LEVEL: rd_val = {4'h0, st_reg.dev[sel].interrupt_request_level};
        pldc_pkg::IDX_ITYP: rd_val = {6'h0_0, st_reg.dev[sel].ityp};
        pldc_pkg::IDX_DMA0: rd_val = {5'h0_0, st_reg.dev[sel].dma0};
        pldc_pkg::IDX_DMA1: rd_val = {5'h0_0, st_reg.dev[sel].dma1};
        default: rd_val = pldc_pkg::ZERO_B;
      endcase
    end
    // data stand only in the cycle after the strobe
    st_next.rdata = cfg_rd_i ? rd_val : pldc_pkg::ZERO_B;

    // io answer: lowest checking device sets the pattern if two ranges overlap
    st_next.io_data = pldc_pkg::ZERO_B;
    st_next.io_drive = 1'b0;
    st_next.io_sel = '0;
    for (int d = pldc_pkg::NUM_DEV - 1; d >= 0; d--) begin
      if (io_rd_i && in_range[d]) begin
        if (st_reg.dev[d].act) begin
          // active device: its function answers, no pattern
          st_next.io_sel[d] = 1'b1;
        end else if (st_reg.dev[d].rc_en) begin
          pat_hit = 1'b1;
          st_next.io_drive = 1'b1;
          st_next.io_data = st_reg.dev[d].rc_pat ? pldc_pkg::PAT_SET
                                                 : pldc_pkg::PAT_CLR;
        end
      end
    end
    // an active device may still overlap a checking one
    if (pat_hit) begin
      st_next.io_sel = '0;
    end

    // resource validity follows the stored selections
    for (int d = 0; d < pldc_pkg::NUM_DEV; d++) begin
      st_next.irq_val[d] = st_next.dev[d].interrupt_request_level != pldc_pkg::IRQ_NONE;
      st_next.dma0_val[d] = st_next.dev[d].dma0 != pldc_pkg::DMA_CASCADE;
      st_next.dma1_val[d] = st_next.dev[d].dma1 != pldc_pkg::DMA_CASCADE;
    end

    // interrupt pins; edge and level both pass the request as a level
    for (int d = 0; d < pldc_pkg::NUM_DEV; d++) begin
      asserted = irq_req_i[d] && st_reg.irq_val[d] && st_reg.dev[d].act;
      st_next.req_q[d] = asserted;
      if (st_reg.dev[d].ityp[pldc_pkg::ITYP_POL_BIT]) begin
        st_next.irq_pin[d] = asserted;
        st_next.irq_oe_n[d] = 1'b0;
        st_next.pu_cnt[d] = 2'h0;
      end else if (asserted) begin
        st_next.irq_pin[d] = 1'b0;
        st_next.irq_oe_n[d] = 1'b0;
        st_next.pu_cnt[d] = 2'h0;
      end else if (st_reg.req_q[d] || st_reg.pu_cnt[d] != 2'h0) begin
        // strong drive high first, so the weak pull-up need not slew
        st_next.irq_pin[d] = 1'b1;
        st_next.irq_oe_n[d] = 1'b0;
        st_next.pu_cnt[d] = st_reg.req_q[d] ? pldc_pkg::STRONG_PU_CYC - 2'h1
                                            : st_reg.pu_cnt[d] - 2'h1;
      end else begin
        st_next.irq_pin[d] = 1'b1;
        st_next.irq_oe_n[d] = 1'b1; // released to the weak pull-up
        st_next.pu_cnt[d] = 2'h0;
      end
    end
  end

  // single register for the whole state
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.irq_pin <= '1;
      st_reg.irq_oe_n <= '1;
      st_reg.dma0_val <= '1;
      st_reg.dma1_val <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign cfg_rdata_o = st_reg.rdata;
  assign io_data_o = st_reg.io_data;
  assign io_drive_o = st_reg.io_drive;
  assign io_sel_o = st_reg.io_sel;
  assign dev_cfg_o = st_reg.dev;
  assign irq_valid_o = st_reg.irq_val;
  assign dma0_valid_o = st_reg.dma0_val;
  assign dma1_valid_o = st_reg.dma1_val;
  assign irq_pin_o = st_reg.irq_pin;
  assign irq_oe_n_o = st_reg.irq_oe_n;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wr_sel(logic [7:0] idx);
    cfg_wr_i && sel_ok && cfg_addr_i == idx;
  endsequence

  sequence s_pat_read(logic pat);
    io_rd_i && in_range[0] && !st_reg.dev[0].act && st_reg.dev[0].rc_en &&
      st_reg.dev[0].rc_pat == pat;
  endsequence

  sequence s_od_release;
    !st_reg.dev[0].ityp[pldc_pkg::ITYP_POL_BIT] && st_reg.req_q[0] &&
      !irq_req_i[0] && $stable(st_reg.dev[0].ityp);
  endsequence

  // request held off and open-drain kept while the pull-up runs
  sequence s_od_quiet;
    !irq_req_i[0] && !st_reg.dev[0].ityp[pldc_pkg::ITYP_POL_BIT];
  endsequence

  a_act_bit_write: assert property (
    s_wr_sel(pldc_pkg::IDX_ACT) |=> st_reg.dev[$past(sel)].act == $past(cfg_wdata_i[0])
  ) else $error("activation bit not stored");

  a_other_dev_kept: assert property (
    (cfg_wr_i && st_reg.ldn != 8'h01) |=> $stable(st_reg.dev[1])
  ) else $error("unselected device changed");

  a_act_read_zero: assert property (
    (cfg_rd_i && sel_ok && cfg_addr_i == pldc_pkg::IDX_ACT) |=> cfg_rdata_o[7:1] == 7'h0_0
  ) else $error("activation reserved bits not zero");

  a_rc_read_zero: assert property (
    (cfg_rd_i && cfg_addr_i == pldc_pkg::IDX_RC) |=> cfg_rdata_o[7:2] == 6'h0_0
  ) else $error("check reserved bits not zero");

  a_base_hi_zero: assert property (
    (cfg_rd_i && (cfg_addr_i == pldc_pkg::IDX_B0H || cfg_addr_i == pldc_pkg::IDX_B1H))
      |=> cfg_rdata_o[7:3] == 5'h0_0
  ) else $error("base high byte upper bits not zero");

  a_pattern_set: assert property (
    s_pat_read(1'b1) |=> io_drive_o && io_data_o == pldc_pkg::PAT_SET
  ) else $error("pattern 55 not returned");

  a_pattern_clr: assert property (
    s_pat_read(1'b0) |=> io_drive_o && io_data_o == pldc_pkg::PAT_CLR
  ) else $error("pattern AA not returned");

  a_active_no_pat: assert property (
    (st_reg.dev == $past(st_reg.dev) && io_drive_o) |->
      $past(io_rd_i) && ($past(~st_reg.dev[0].act & st_reg.dev[0].rc_en & in_range[0]) |
      $past(~st_reg.dev[1].act & st_reg.dev[1].rc_en & in_range[1]) |
      $past(~st_reg.dev[2].act & st_reg.dev[2].rc_en & in_range[2]) |
      $past(~st_reg.dev[3].act & st_reg.dev[3].rc_en & in_range[3]))
  ) else $error("pattern driven without an inactive checking device");

  a_sel_only_active: assert property (
    io_sel_o[0] |-> $past(st_reg.dev[0].act) && $past(io_rd_i)
  ) else $error("inactive device selected");

  a_dma_cascade: assert property (
    (s_wr_sel(pldc_pkg::IDX_DMA0) and (cfg_wdata_i[2:0] == pldc_pkg::DMA_CASCADE)
      and (sel == 2'h0)) |=> !dma0_valid_o[0]
  ) else $error("cascade channel reported valid");

  a_irq_none: assert property (
    (st_reg.dev[0].interrupt_request_level == pldc_pkg::IRQ_NONE) |-> !irq_valid_o[0]
  ) else $error("level zero reported as assigned");

  a_push_pull: assert property (
    st_reg.dev[0].ityp[pldc_pkg::ITYP_POL_BIT] ##1
      st_reg.dev[0].ityp[pldc_pkg::ITYP_POL_BIT] |-> !irq_oe_n_o[0]
  ) else $error("push-pull pin released");

  a_od_pullup: assert property (
    s_od_release ##1 s_od_quiet ##1 s_od_quiet |->
      irq_pin_o[0] && !irq_oe_n_o[0] && $past(irq_pin_o[0]) && !$past(irq_oe_n_o[0])
      ##1 irq_oe_n_o[0]
  ) else $error("open-drain strong pull-up timing wrong");

  // device number and the copy it selects
  a_ldn_write: assert property (
    (cfg_wr_i && cfg_addr_i == pldc_pkg::IDX_LDN) |=> st_reg.ldn == $past(cfg_wdata_i)
  ) else $error("device number not stored");

  a_unsel_write_drop: assert property (
    (cfg_wr_i && !sel_ok) |=> $stable(st_reg.dev)
  ) else $error("write landed with no device selected");

  a_unsel_read_zero: assert property (
    (cfg_rd_i && !sel_ok && cfg_addr_i != pldc_pkg::IDX_LDN) |=>
      cfg_rdata_o == pldc_pkg::ZERO_B
  ) else $error("read returned data with no device selected");

  a_act_read_back: assert property (
    (cfg_rd_i && sel_ok && cfg_addr_i == pldc_pkg::IDX_ACT) |=>
      cfg_rdata_o[pldc_pkg::ACT_BIT] == $past(st_reg.dev[sel].act)
  ) else $error("activation bit read back wrong");

  // each field write lands in the selected copy; of the interrupt type only the level bit is checked
  a_rc_write: assert property (
    s_wr_sel(pldc_pkg::IDX_RC) |=>
      st_reg.dev[$past(sel)].rc_en == $past(cfg_wdata_i[pldc_pkg::RC_EN_BIT]) &&
      st_reg.dev[$past(sel)].rc_pat == $past(cfg_wdata_i[pldc_pkg::RC_PAT_BIT])
  ) else $error("range check bits not stored");

  a_b0h_write: assert property (
    s_wr_sel(pldc_pkg::IDX_B0H) |=> st_reg.dev[$past(sel)].b0h == $past(cfg_wdata_i[2:0])
  ) else $error("descriptor zero high bits not stored");

  a_b0l_write: assert property (
    s_wr_sel(pldc_pkg::IDX_B0L) |=> st_reg.dev[$past(sel)].b0l == $past(cfg_wdata_i)
  ) else $error("descriptor zero low byte not stored");

  a_b1h_write: assert property (
    s_wr_sel(pldc_pkg::IDX_B1H) |=> st_reg.dev[$past(sel)].b1h == $past(cfg_wdata_i[2:0])
  ) else $error("descriptor one high bits not stored");

  a_b1l_write: assert property (
    s_wr_sel(pldc_pkg::IDX_B1L) |=> st_reg.dev[$past(sel)].b1l == $past(cfg_wdata_i)
  ) else $error("descriptor one low byte not stored");

  a_interrupt_request_level_write: assert property (
    s_wr_sel(pldc_pkg::IDX_INTERRUPT_REQUEST_LEVEL) |=> st_reg.dev[$past(sel)].interrupt_request_level == $past(cfg_wdata_i[3:0])
  ) else $error("interrupt level not stored");

  a_irq_level: assert property (
    (st_reg.dev[0].interrupt_request_level != pldc_pkg::IRQ_NONE) |-> irq_valid_o[0]
  ) else $error("assigned level reported as none");

  a_ityp_write: assert property (
    (s_wr_sel(pldc_pkg::IDX_ITYP) and
      pldc_pkg::ITYP_WR_MASK[pldc_pkg::ITYP_LVL_BIT]) |=>
      st_reg.dev[$past(sel)].ityp[pldc_pkg::ITYP_LVL_BIT] ==
      $past(cfg_wdata_i[pldc_pkg::ITYP_LVL_BIT])
  ) else $error("edge or level bit not stored");

  a_dma0_write: assert property (
    s_wr_sel(pldc_pkg::IDX_DMA0) |=> st_reg.dev[$past(sel)].dma0 == $past(cfg_wdata_i[2:0])
  ) else $error("first channel not stored");

  a_dma1_write: assert property (
    s_wr_sel(pldc_pkg::IDX_DMA1) |=> st_reg.dev[$past(sel)].dma1 == $past(cfg_wdata_i[2:0])
  ) else $error("second channel not stored");

  a_dma1_cascade: assert property (
    (s_wr_sel(pldc_pkg::IDX_DMA1) and (cfg_wdata_i[2:0] == pldc_pkg::DMA_CASCADE)
      and (sel == 2'h0)) |=> !dma1_valid_o[0]
  ) else $error("second cascade channel reported valid");

  a_pat_hides_sel: assert property (
    io_drive_o |-> io_sel_o == '0
  ) else $error("device selected while pattern driven");

  // interrupt pin in both drive styles
  a_od_low_drive: assert property (
    (!st_reg.dev[0].ityp[pldc_pkg::ITYP_POL_BIT] && irq_req_i[0] && st_reg.irq_val[0] &&
      st_reg.dev[0].act) |=> !irq_pin_o[0] && !irq_oe_n_o[0]
  ) else $error("open-drain pin not pulled low");

  a_pp_follow: assert property (
    st_reg.dev[0].ityp[pldc_pkg::ITYP_POL_BIT] |=> !irq_oe_n_o[0] &&
      irq_pin_o[0] == $past(irq_req_i[0] && st_reg.irq_val[0] && st_reg.dev[0].act)
  ) else $error("push-pull pin does not follow the request");
endmodule : pldc_top

// ==== shared/pldc_pkg.sv ====
package pldc_pkg;
  // number of logical devices that own a copy of the set
  localparam int NUM_DEV = 4;
  localparam logic [7:0] NUM_DEV_B = 8'h04;

  // register indices
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_RC = 8'h31;
  localparam logic [7:0] IDX_B0H = 8'h60;
  localparam logic [7:0] IDX_B0L = 8'h61;
  localparam logic [7:0] IDX_B1H = 8'h62;
  localparam logic [7:0] IDX_B1L = 8'h63;
  localparam logic [7:0] IDX_INTERRUPT_REQUEST_LEVEL = 8'h70;
  localparam logic [7:0] IDX_ITYP = 8'h71;
  localparam logic [7:0] IDX_DMA0 = 8'h74;
  localparam logic [7:0] IDX_DMA1 = 8'h75;

  // field positions
  localparam int ACT_BIT = 0;
  localparam int RC_PAT_BIT = 0;
  localparam int RC_EN_BIT = 1;
  localparam int ITYP_LVL_BIT = 0;
  localparam int ITYP_POL_BIT = 1;

  // fixed values
  localparam logic [7:0] PAT_SET = 8'h55;
  localparam logic [7:0] PAT_CLR = 8'hAA;
  localparam logic [2:0] DMA_CASCADE = 3'h4;
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [7:0] ZERO_B = 8'h00;
  // ports decoded per descriptor
  localparam logic [15:0] IO_RANGE_LEN = 16'h0008;
  // writable bits of the interrupt type; 2'b00 makes it read-only
  localparam logic [1:0] ITYP_WR_MASK = 2'h3;

  // strong pull-up after an open-drain release
  localparam int CLK_NS = 25;
  localparam int STRONG_PU_NS = 50;
  localparam logic [1:0] STRONG_PU_CYC = 2'((STRONG_PU_NS + CLK_NS - 1) / CLK_NS);

  // configuration of one logical device
  typedef struct packed {
    logic act;
    logic rc_en;
    logic rc_pat;
    logic [2:0] b0h;
    logic [7:0] b0l;
    logic [2:0] b1h;
    logic [7:0] b1l;
    logic [3:0] interrupt_request_level;
    logic [1:0] ityp;
    logic [2:0] dma0;
    logic [2:0] dma1;
  } pldc_dev_t;

  localparam pldc_dev_t DEV_RST = '0;

  typedef struct packed {
    pldc_dev_t [NUM_DEV-1:0] dev;
    logic [7:0] ldn;
    logic [7:0] rdata;
    logic [7:0] io_data;
    logic io_drive;
    logic [NUM_DEV-1:0] io_sel;
    logic [NUM_DEV-1:0] irq_val;
    logic [NUM_DEV-1:0] dma0_val;
    logic [NUM_DEV-1:0] dma1_val;
    logic [NUM_DEV-1:0] irq_pin;
    logic [NUM_DEV-1:0] irq_oe_n;
    logic [NUM_DEV-1:0] req_q;
    logic [NUM_DEV-1:0][1:0] pu_cnt;
  } pldc_state_t;
endpackage : pldc_pkg

// ==== tb/pldc_host_model.sv ====
`timescale 1ns/10ps
module pldc_host_model (
  input wire logic [pldc_pkg::NUM_DEV-1:0] irq_pin_i,
  input wire logic [pldc_pkg::NUM_DEV-1:0] irq_oe_n_i,
  output logic [pldc_pkg::NUM_DEV-1:0] irq_line_o
);
  // released line floats up through the board's weak pull-up, never holds a stale level
  always_comb begin
    for (int i = 0; i < pldc_pkg::NUM_DEV; i++) begin
      irq_line_o[i] = irq_oe_n_i[i] ? 1'b1 : irq_pin_i[i];
    end
  end
endmodule : pldc_host_model

// ==== tb/pldc_top_bench.sv ====
`timescale 1ns/10ps
module pldc_top_bench;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [7:0] cfg_wdata_i = 8'h00;
  logic cfg_wr_i = 1'b0;
  logic cfg_rd_i = 1'b0;
  logic [7:0] cfg_rdata_o;
  logic [15:0] io_addr_i = 16'h0000;
  logic io_rd_i = 1'b0;
  logic [3:0] irq_req_i = 4'h0;
  logic [7:0] io_data_o;
  logic io_drive_o;
  logic [3:0] io_sel_o;
  pldc_pkg::pldc_dev_t [3:0] dev_cfg_o;
  logic [3:0] irq_valid_o;
  logic [3:0] dma0_valid_o;
  logic [3:0] dma1_valid_o;
  logic [3:0] irq_pin_o;
  logic [3:0] irq_oe_n_o;
  logic [3:0] irq_line;
  int miscompares = 0;
  int cmp_count = 0;

  pldc_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_rdata_o(cfg_rdata_o), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
    .irq_req_i(irq_req_i), .io_data_o(io_data_o), .io_drive_o(io_drive_o),
    .io_sel_o(io_sel_o), .dev_cfg_o(dev_cfg_o), .irq_valid_o(irq_valid_o),
    .dma0_valid_o(dma0_valid_o), .dma1_valid_o(dma1_valid_o),
    .irq_pin_o(irq_pin_o), .irq_oe_n_o(irq_oe_n_o));

  pldc_host_model host (.irq_pin_i(irq_pin_o), .irq_oe_n_i(irq_oe_n_o), .irq_line_o(irq_line));

  // 40 MHz system clock
  always #12.5 sys_clk_i = ~sys_clk_i;

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1

  // idle edge after each strobe keeps one assignment per signal per time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    cfg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    cfg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr

  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cfg_addr_i <= a;
    cfg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    cfg_rd_i <= 1'b0;
    #1 chk8(cfg_rdata_o, e);
    @(posedge sys_clk_i);
  endtask : rd

  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    wr(a, d);
    rd(a, e);
  endtask : wrrd

  task automatic iord(input logic [15:0] a, input logic drv, input logic [7:0] dat,
                      input logic [7:0] sel);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    io_rd_i <= 1'b0;
    #1 chk1(io_drive_o, drv);
    if (drv) begin
      chk8(io_data_o, dat);
    end
    chk8(8'(io_sel_o), sel);
    @(posedge sys_clk_i);
  endtask : iord

  // request then release on device zero, pol is the asserted pin level
  task automatic irq_walk(input logic pol);
    irq_req_i <= 4'h1;
    @(posedge sys_clk_i);
    #1 chk1(irq_pin_o[0], pol);
    chk1(irq_oe_n_o[0], 1'b0);
    @(posedge sys_clk_i);
    irq_req_i <= 4'h0;
    // both cycles of the strong drive after release
    repeat (2) begin
      @(posedge sys_clk_i);
      #1 chk1(irq_pin_o[0], ~pol);
      chk1(irq_oe_n_o[0], 1'b0);
      chk1(irq_line[0], ~pol);
    end
    @(posedge sys_clk_i);
    #1 chk1(irq_oe_n_o[0], ~pol);
    chk1(irq_line[0], ~pol);
    @(posedge sys_clk_i);
  endtask : irq_walk

  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // cut a hang short
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    wrrd(pldc_pkg::IDX_ACT, 8'hFE, 8'h00);
    wrrd(pldc_pkg::IDX_RC, 8'hFF, 8'h03);
    wr(pldc_pkg::IDX_RC, 8'h00);
    wrrd(pldc_pkg::IDX_ACT, 8'hFF, 8'h01);
    chk1(dev_cfg_o[0].act, 1'b1);
    wr(pldc_pkg::IDX_ACT, 8'h00);
    wrrd(pldc_pkg::IDX_B0H, 8'hFF, 8'h07);
    wrrd(pldc_pkg::IDX_B0L, 8'hA5, 8'hA5);
    wrrd(pldc_pkg::IDX_B1H, 8'hFA, 8'h02);
    wrrd(pldc_pkg::IDX_B1L, 8'h5A, 8'h5A);
    wrrd(pldc_pkg::IDX_INTERRUPT_REQUEST_LEVEL, 8'h0F, 8'h0F);
    chk1(irq_valid_o[0], 1'b1);
    wr(pldc_pkg::IDX_INTERRUPT_REQUEST_LEVEL, 8'h00);
    chk1(irq_valid_o[0], 1'b0);
    wrrd(pldc_pkg::IDX_ITYP, 8'h03, 8'h03);
    chk1(dev_cfg_o[0].ityp[0], 1'b1);
    wrrd(pldc_pkg::IDX_ITYP, 8'h02, 8'h02);
    // every channel code on both selects, cascade code included
    for (int c = 0; c < 8; c++) begin
      wrrd(pldc_pkg::IDX_DMA0, 8'(c), 8'(c));
      chk1(dma0_valid_o[0], c != 4);
      wrrd(pldc_pkg::IDX_DMA1, 8'(c), 8'(c));
      chk1(dma1_valid_o[0], c != 4);
    end
    // another device's copy, then a device number past the last copy
    wr(pldc_pkg::IDX_LDN, 8'h01);
    rd(pldc_pkg::IDX_B0L, 8'h00);
    wrrd(pldc_pkg::IDX_B0L, 8'h11, 8'h11);
    wr(pldc_pkg::IDX_ACT, 8'h01);
    chk1(dev_cfg_o[1].act, 1'b1);
    chk1(dev_cfg_o[0].act, 1'b0);
    wr(pldc_pkg::IDX_LDN, 8'h04);
    wr(pldc_pkg::IDX_B0L, 8'h77);
    rd(pldc_pkg::IDX_B0L, 8'h00);
    wr(pldc_pkg::IDX_LDN, 8'h00);
    rd(pldc_pkg::IDX_B0L, 8'hA5);
    rd(8'h40, 8'h00);
    // conflict check on device zero: ranges 0x0300 and 0x0200, 8 ports each
    wr(pldc_pkg::IDX_B0H, 8'h03);
    wr(pldc_pkg::IDX_B0L, 8'h00);
    wr(pldc_pkg::IDX_B1H, 8'h02);
    wr(pldc_pkg::IDX_B1L, 8'h00);
    wr(pldc_pkg::IDX_RC, 8'h03);
    iord(16'h0302, 1'b1, pldc_pkg::PAT_SET, 8'h00);
    iord(16'h0207, 1'b1, pldc_pkg::PAT_SET, 8'h00);
    wr(pldc_pkg::IDX_RC, 8'h02);
    iord(16'h0300, 1'b1, pldc_pkg::PAT_CLR, 8'h00);
    iord(16'h0308, 1'b0, 8'h00, 8'h00);
    wr(pldc_pkg::IDX_RC, 8'h00);
    iord(16'h0302, 1'b0, 8'h00, 8'h00);
    wr(pldc_pkg::IDX_ACT, 8'h01);
    iord(16'h0307, 1'b0, 8'h00, 8'h01);
    wr(pldc_pkg::IDX_RC, 8'h03);
    iord(16'h0302, 1'b0, 8'h00, 8'h01);
    wr(pldc_pkg::IDX_RC, 8'h00);
    iord(16'h0200, 1'b0, 8'h00, 8'h01);
    // interrupt pin, device zero active at level 5
    wr(pldc_pkg::IDX_INTERRUPT_REQUEST_LEVEL, 8'h05);
    wr(pldc_pkg::IDX_ITYP, 8'h02);
    irq_walk(1'b1);
    wr(pldc_pkg::IDX_ITYP, 8'h00);
    irq_walk(1'b0);
    wr(pldc_pkg::IDX_INTERRUPT_REQUEST_LEVEL, 8'h00);
    irq_req_i <= 4'h1;
    repeat (2) @(posedge sys_clk_i);
    #1 chk1(irq_oe_n_o[0], 1'b1);
    @(posedge sys_clk_i);
    irq_req_i <= 4'h0;
    give_verdict();
  end
endmodule : pldc_top_bench
